/* design/aic_pkg.sv */
// Purpose: Shared constants and types for the analog input conditioning block
// Assumes: Samples arrive as unsigned 16-bit codes, full scale at 0xffff
// Notes:   Setpoints use 0.1 V / 0.1 mA units, percentages use 0.01 % units
package aic_pkg;
   localparam int unsigned CLK_HZ          = 125000000;
   localparam int unsigned TICK_US         = 1000;
   localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000000 * TICK_US;
   localparam logic [15:0] ADC_FULL        = 16'hffff;
   // Register offsets
   localparam logic [3:0]  REG_CTRL        = 4'h0;
   localparam logic [3:0]  REG_VMIN        = 4'h1;
   localparam logic [3:0]  REG_VMAX        = 4'h2;
   localparam logic [3:0]  REG_IMIN        = 4'h3;
   localparam logic [3:0]  REG_IMAX        = 4'h4;
   localparam logic [3:0]  REG_FILT        = 4'h5;
   localparam logic [3:0]  REG_BENDX       = 4'h6;
   localparam logic [3:0]  REG_BENDY       = 4'h7;
   localparam logic [3:0]  REG_ASSIGN      = 4'h8;
   localparam logic [3:0]  REG_RESULT      = 4'h9;
   localparam logic [3:0]  REG_CH2         = 4'ha;
   // Control fields
   localparam int unsigned CTRL_KIND_BIT   = 0;
   localparam int unsigned CTRL_SPAN_BIT   = 1;
   localparam int unsigned CH2_BIPOLAR_BIT = 0;
   // Reset values, full scales and limits
   localparam logic [15:0] VMIN_RST        = 16'h0000;
   localparam logic [15:0] VMAX_RST        = 16'h0064;
   localparam logic [15:0] IMIN_RST        = 16'h0000;
   localparam logic [15:0] IMAX_RST        = 16'h00c8;
   localparam logic [15:0] FILT_RST        = 16'h0000;
   localparam logic [15:0] BEND_RST        = 16'h0000;
   localparam logic [15:0] VOLT_FULL       = 16'h0064;
   localparam logic [15:0] CURR_FULL       = 16'h00c8;
   localparam logic [15:0] IMIN_BIDIR      = 16'h001e;
   localparam logic [15:0] FILT_MAX        = 16'h03e8;
   localparam logic [15:0] PCT_FULL        = 16'h2710;
   localparam logic [15:0] ASSIGN_NONE     = 16'h0000;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_SCALE = 4'b0010,
      ST_BEND  = 4'b0100,
      ST_FILT  = 4'b1000
   } pipe_state_t;

   typedef struct packed {
      logic [3:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } reg_req_t;
endpackage : aic_pkg

/* design/seg_interp.sv */
// Purpose: One linear segment between two points, clamped to the segment
// Assumes: x0 <= x1; values in 0.01 % units
// Notes:   Division is combinational; fine at this width and rate
`timescale 1ns/100ps
module seg_interp
   import aic_pkg::*;
(
   input  wire logic [15:0] x,
   input  wire logic [15:0] x0,
   input  wire logic [15:0] x1,
   input  wire logic [15:0] y0,
   input  wire logic [15:0] y1,
   output logic      [15:0] y
);
   logic signed [33:0] num;
   logic signed [33:0] res;
   logic        [15:0] dx;
   always_comb begin
      dx  = x1 - x0;
      num = 34'(signed'({1'b0, x - x0})) * 34'(signed'({1'b0, y1}) - signed'({1'b0, y0}));
      // The far end wins on a segment of no width, so the bend point is always reached
      if (x >= x1) begin
         res = 34'(signed'({1'b0, y1}));
      end else if (x <= x0 || dx == 16'h0000) begin
         res = 34'(signed'({1'b0, y0}));
      end else begin
         res = 34'(signed'({1'b0, y0})) + num / 34'(signed'({1'b0, dx}));
      end
      y = res[15:0];
   end
endmodule : seg_interp

/* design/analog_input_conditioning.sv */
// Purpose: Scale, bend and filter one converted analog input channel
// Assumes: Sample valid pulses slower than four clocks; setpoints written by software
// Notes:   Result in 0.01 % units, signed in bidirectional span
`timescale 1ns/100ps
module analog_input_conditioning
   import aic_pkg::*;
#(
   parameter int unsigned TICK_LEN = TICK_CYCLES
)
(
   input  wire logic        mclk,
   input  wire logic        resetn,
   input  wire logic [3:0]  regAddr,
   input  wire logic [15:0] regWdata,
   input  wire logic        regWr,
   input  wire logic        regRd,
   output logic      [15:0] regRdata,
   input  wire logic [15:0] sampleIn,
   input  wire logic        sampleValid,
   input  wire logic [15:0] assignedFuncs,
   output logic      [15:0] refOut,
   output logic             refValid,
   output logic             channelKindCurrent,
   output logic             channelTwoBipolar
);
   reg_req_t req;
   assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

   logic [15:0] ctrl_reg, ctrl_next, vmin_reg, vmin_next, vmax_reg, vmax_next;
   logic [15:0] imin_reg, imin_next, imax_reg, imax_next, filt_reg, filt_next;
   logic [15:0] bx_reg, bx_next, by_reg, by_next, rdata_reg, rdata_next;
   logic        ch2_reg, ch2_next;
   logic        kindCurrent, bidir;

   always_comb begin
      ctrl_next = ctrl_reg;
      vmin_next = vmin_reg;
      vmax_next = vmax_reg;
      imin_next = imin_reg;
      imax_next = imax_reg;
      filt_next = filt_reg;
      bx_next   = bx_reg;
      by_next   = by_reg;
      ch2_next  = ch2_reg;
      if (req.wr) begin
         case (req.addr)
            REG_CTRL:  ctrl_next = req.wdata & 16'h0003;
            REG_VMIN:  vmin_next = (req.wdata > VOLT_FULL) ? VOLT_FULL : req.wdata;
            REG_VMAX:  vmax_next = (req.wdata > VOLT_FULL) ? VOLT_FULL : req.wdata;
            REG_IMIN:  imin_next = (req.wdata > CURR_FULL) ? CURR_FULL : req.wdata;
            REG_IMAX:  imax_next = (req.wdata > CURR_FULL) ? CURR_FULL : req.wdata;
            REG_FILT:  filt_next = (req.wdata > FILT_MAX) ? FILT_MAX : req.wdata;
            REG_BENDX: bx_next   = (req.wdata > PCT_FULL) ? PCT_FULL : req.wdata;
            REG_BENDY: by_next   = (req.wdata > PCT_FULL) ? PCT_FULL : req.wdata;
            REG_CH2:   ch2_next  = req.wdata[CH2_BIPOLAR_BIT];
            default:   ctrl_next = ctrl_reg;
         endcase
      end
   end

   assign kindCurrent = ctrl_reg[CTRL_KIND_BIT];
   // Span selection only holds while the minimum is high enough to sense a broken loop
   assign bidir = kindCurrent && (imin_reg >= IMIN_BIDIR) && ctrl_reg[CTRL_SPAN_BIT];

   // Scaled value, pipeline state and filter
   pipe_state_t st_reg, st_next;
   logic [15:0] raw_reg, raw_next, pct_reg, pct_next, bent_reg, bent_next;
   logic [31:0] acc_reg, acc_next;
   logic [31:0] tick_reg, tick_next;
   logic [15:0] out_reg, out_next;
   logic        vld_reg, vld_next;
   logic [15:0] loPt, hiPt, segA, segB, bentVal;
   logic [31:0] phys, span, scaled;
   logic        tick;

   // Scaling points are chosen by the channel kind; the other pair stays stored
   assign loPt = kindCurrent ? imin_reg : vmin_reg;
   assign hiPt = kindCurrent ? imax_reg : vmax_reg;

   seg_interp lowSeg (
      .x  (pct_reg),
      .x0 (16'h0000),
      .x1 (bx_reg),
      .y0 (16'h0000),
      .y1 (by_reg),
      .y  (segA)
   );
   seg_interp highSeg (
      .x  (pct_reg),
      .x0 (bx_reg),
      .x1 (PCT_FULL),
      .y0 (by_reg),
      .y1 (PCT_FULL),
      .y  (segB)
   );
   // Pick the segment on which the sample lies
   assign bentVal = (pct_reg <= bx_reg) ? segA : segB;

   assign tick = (tick_reg == TICK_LEN - 1);

   always_comb begin
      st_next   = st_reg;
      raw_next  = raw_reg;
      pct_next  = pct_reg;
      bent_next = bent_reg;
      acc_next  = acc_reg;
      out_next  = out_reg;
      vld_next  = 1'b0;
      tick_next = tick ? 32'h0 : tick_reg + 32'h1;
      phys      = 32'(raw_reg) * 32'(kindCurrent ? CURR_FULL : VOLT_FULL) / 32'(ADC_FULL);
      span      = (hiPt > loPt) ? 32'(hiPt - loPt) : 32'h1;
      if (phys <= 32'(loPt)) begin
         scaled = 32'h0;
      end else if (phys >= 32'(hiPt)) begin
         scaled = 32'(PCT_FULL);
      end else begin
         scaled = (phys - 32'(loPt)) * 32'(PCT_FULL) / span;
      end
      case (st_reg)
         ST_IDLE: begin
            if (sampleValid) begin
               raw_next = sampleIn;
               st_next  = ST_SCALE;
            end
         end
         ST_SCALE: begin
            pct_next = scaled[15:0];
            st_next  = ST_BEND;
         end
         ST_BEND: begin
            bent_next = bentVal;
            st_next   = ST_FILT;
         end
         ST_FILT: begin
            // Filter state is in 1/65536 units of 0.01 %
            // A set cutoff reports the held accumulator; the tick moves it on
            if (filt_reg == FILT_RST) begin
               acc_next = {bent_reg, 16'h0000};
            end else begin
               acc_next = acc_reg;
            end
            if (bidir) begin
               out_next = 16'((32'(acc_next[31:16]) << 1) - 32'(PCT_FULL));
            end else begin
               out_next = acc_next[31:16];
            end
            vld_next = 1'b1;
            st_next  = ST_IDLE;
         end
         default: st_next = ST_IDLE;
      endcase
      // First order update once per millisecond, time constant in 10 ms units
      if (tick && filt_reg != FILT_RST) begin
         if ({bent_reg, 16'h0000} >= acc_reg) begin
            acc_next = acc_reg + ((({bent_reg, 16'h0000} - acc_reg) / 32'(filt_reg)) / 32'd10);
         end else begin
            acc_next = acc_reg - (((acc_reg - {bent_reg, 16'h0000}) / 32'(filt_reg)) / 32'd10);
         end
      end
   end

   // Read data returns to zero whenever no read is strobed
   always_comb begin
      rdata_next = 16'h0000;
      if (req.rd) begin
         case (req.addr)
            REG_CTRL:   rdata_next = {14'h0, bidir, kindCurrent};
            REG_VMIN:   rdata_next = vmin_reg;
            REG_VMAX:   rdata_next = vmax_reg;
            REG_IMIN:   rdata_next = imin_reg;
            REG_IMAX:   rdata_next = imax_reg;
            REG_FILT:   rdata_next = filt_reg;
            REG_BENDX:  rdata_next = bx_reg;
            REG_BENDY:  rdata_next = by_reg;
            REG_ASSIGN: rdata_next = assignedFuncs;
            REG_RESULT: rdata_next = out_reg;
            REG_CH2:    rdata_next = {15'h0, ch2_reg};
            default:    rdata_next = 16'h0000;
         endcase
      end
   end

   // One synchronous reset for every register of the block
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         ctrl_reg  <= 16'h0000;
         vmin_reg  <= VMIN_RST;
         vmax_reg  <= VMAX_RST;
         imin_reg  <= IMIN_RST;
         imax_reg  <= IMAX_RST;
         filt_reg  <= FILT_RST;
         bx_reg    <= BEND_RST;
         by_reg    <= BEND_RST;
         ch2_reg   <= 1'b1;
         rdata_reg <= 16'h0000;
         st_reg    <= ST_IDLE;
         raw_reg   <= 16'h0000;
         pct_reg   <= 16'h0000;
         bent_reg  <= 16'h0000;
         acc_reg   <= 32'h0;
         out_reg   <= 16'h0000;
         vld_reg   <= 1'b0;
         tick_reg  <= 32'h0;
      end else begin
         ctrl_reg  <= ctrl_next;
         vmin_reg  <= vmin_next;
         vmax_reg  <= vmax_next;
         imin_reg  <= imin_next;
         imax_reg  <= imax_next;
         filt_reg  <= filt_next;
         bx_reg    <= bx_next;
         by_reg    <= by_next;
         ch2_reg   <= ch2_next;
         rdata_reg <= rdata_next;
         st_reg    <= st_next;
         raw_reg   <= raw_next;
         pct_reg   <= pct_next;
         bent_reg  <= bent_next;
         acc_reg   <= acc_next;
         out_reg   <= out_next;
         vld_reg   <= vld_next;
         tick_reg  <= tick_next;
      end
   end

   assign regRdata           = rdata_reg;
   assign refOut             = out_reg;
   assign refValid           = vld_reg;
   assign channelKindCurrent = kindCurrent;
   assign channelTwoBipolar  = ch2_reg;

   // Checks
   a_kind_default: assert property (@(posedge mclk)
      $rose(resetn) |-> !channelKindCurrent)
      else $error("channel kind not voltage after reset");
   a_ch2_default: assert property (@(posedge mclk)
      $rose(resetn) |-> channelTwoBipolar)
      else $error("channel two not bipolar after reset");
   a_span_forced: assert property (@(posedge mclk) disable iff (!resetn)
      refValid && (!$past(kindCurrent) || $past(imin_reg) < IMIN_BIDIR)
      |-> refOut <= PCT_FULL)
      else $error("bidirectional span not forced off");
   a_vmax_limit: assert property (@(posedge mclk) disable iff (!resetn)
      vmax_reg <= VOLT_FULL && vmin_reg <= VOLT_FULL)
      else $error("voltage point beyond ten volts");
   a_imax_limit: assert property (@(posedge mclk) disable iff (!resetn)
      imax_reg <= CURR_FULL && imin_reg <= CURR_FULL)
      else $error("current point beyond twenty milliamperes");
   a_filt_limit: assert property (@(posedge mclk) disable iff (!resetn)
      filt_reg <= FILT_MAX)
      else $error("filter time beyond ten seconds");
   a_bend_pass: assert property (@(posedge mclk) disable iff (!resetn)
      (st_reg == ST_BEND && pct_reg == bx_reg) |=> bent_reg == $past(by_reg))
      else $error("bend point not reached");
   a_filt_bypass: assert property (@(posedge mclk) disable iff (!resetn)
      (st_reg == ST_FILT && filt_reg == FILT_RST && !bidir) |=> refOut == $past(bent_reg))
      else $error("zero cutoff did not pass through");
   a_assign_read: assert property (@(posedge mclk) disable iff (!resetn)
      (regRd && regAddr == REG_ASSIGN) |=> regRdata == $past(assignedFuncs))
      else $error("assignment readback wrong");
   a_sample_latency: assert property (@(posedge mclk) disable iff (!resetn)
      (st_reg == ST_IDLE && sampleValid) |-> ##4 refValid)
      else $error("result not produced four cycles after sample");
   a_kind_write: assert property (@(posedge mclk) disable iff (!resetn)
      (regWr && regAddr == REG_CTRL) |=> channelKindCurrent == $past(regWdata[CTRL_KIND_BIT]))
      else $error("channel kind not taken from write");
   a_ch2_write: assert property (@(posedge mclk) disable iff (!resetn)
      (regWr && regAddr == REG_CH2) |=> channelTwoBipolar == $past(regWdata[CH2_BIPOLAR_BIT]))
      else $error("channel two kind not taken from write");
   a_result_read: assert property (@(posedge mclk) disable iff (!resetn)
      (regRd && regAddr == REG_RESULT) |=> regRdata == $past(refOut))
      else $error("result readback wrong");
   a_valid_pulse: assert property (@(posedge mclk) disable iff (!resetn)
      refValid |=> !refValid)
      else $error("result valid longer than one cycle");
   a_upper_end: assert property (@(posedge mclk) disable iff (!resetn)
      (st_reg == ST_BEND && pct_reg == PCT_FULL && bx_reg != PCT_FULL)
      |=> bent_reg == PCT_FULL)
      else $error("full input did not give full reference");
   a_pct_range: assert property (@(posedge mclk) disable iff (!resetn)
      st_reg == ST_BEND |-> pct_reg <= PCT_FULL)
      else $error("scaled value beyond full span");

   // Main scenarios
   c_bidir: cover property (@(posedge mclk) disable iff (!resetn) bidir && refValid);
   c_current: cover property (@(posedge mclk) disable iff (!resetn) kindCurrent && refValid);
   c_filtered: cover property (@(posedge mclk) disable iff (!resetn)
      filt_reg != 16'h0 && refValid);
   c_upper_seg: cover property (@(posedge mclk) disable iff (!resetn)
      st_reg == ST_BEND && pct_reg > bx_reg);
   c_lower_seg: cover property (@(posedge mclk) disable iff (!resetn)
      st_reg == ST_BEND && pct_reg < bx_reg);
endmodule : analog_input_conditioning

/* verif/analog_source.sv */
// Purpose: Far-side model of the converter feeding one conditioned channel
// Assumes: One code per call; caller keeps at least four cycles between calls
// Notes:   Outside a valid cycle the code lines show the inverse of the last code
`timescale 1ns/100ps
module analog_source (
   input  wire logic        mclk,
   output logic      [15:0] sampleIn,
   output logic             sampleValid
);
   initial begin
      sampleIn    = 16'h0000;
      sampleValid = 1'b0;
   end

   // Stale data is scrambled so a design that latches late cannot pass by luck
   task automatic send(input logic [15:0] code);
      @(posedge mclk);
      sampleIn    <= code;
      sampleValid <= 1'b1;
      @(posedge mclk);
      sampleValid <= 1'b0;
      sampleIn    <= ~code;
   endtask : send
endmodule : analog_source

/* verif/analog_input_conditioning_tb_top.sv */
// Purpose: Self-checking bench for the analog input conditioning block
// Assumes: Filter tick shortened to 10 clocks, so one filter step is 10 cycles
// Notes:   Percent codes are in 0.01 % units, setpoints in 0.1 V / 0.1 mA
`timescale 1ns/100ps
module analog_input_conditioning_tb_top;
   import aic_pkg::*;
   logic        mclk = 1'b0;
   logic        resetn = 1'b0;
   logic [3:0]  regAddr = 4'h0;
   logic [15:0] regWdata = 16'h0000;
   logic        regWr = 1'b0;
   logic        regRd = 1'b0;
   logic [15:0] regRdata;
   logic [15:0] sampleIn;
   logic        sampleValid;
   logic [15:0] assignedFuncs = 16'h0000;
   logic [15:0] refOut;
   logic        refValid;
   logic        channelKindCurrent;
   logic        channelTwoBipolar;
   int          failCount = 0;
   int          numChecks = 0;

   always #4 mclk = ~mclk;

   analog_input_conditioning #(.TICK_LEN(10)) u_analog_input_conditioning (
      .mclk(mclk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .sampleIn(sampleIn),
      .sampleValid(sampleValid), .assignedFuncs(assignedFuncs), .refOut(refOut),
      .refValid(refValid), .channelKindCurrent(channelKindCurrent),
      .channelTwoBipolar(channelTwoBipolar));

   analog_source u_analog_source (
      .mclk(mclk), .sampleIn(sampleIn), .sampleValid(sampleValid));

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      numChecks++;
      if (seen !== exp) begin
         failCount++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk);
      regAddr  <= a;
      regWdata <= d;
      regWr    <= 1'b1;
      @(posedge mclk);
      regWr <= 1'b0;
      // Step off the edge so a caller sees outputs that the write changes
      #1;
   endtask : wr

   // Read data is looked at in the single cycle after the strobe
   task automatic rdchk(input string name, input logic [3:0] a, input logic [15:0] exp);
      @(posedge mclk);
      regAddr <= a;
      regRd   <= 1'b1;
      @(posedge mclk);
      regRd <= 1'b0;
      #1;
      check(name, regRdata, exp);
   endtask : rdchk

   // Sends one code; refValid seen after edge n is sampled high at edge n + 1 after taking
   task automatic sample(input string name, input logic [15:0] code, input logic [15:0] exp);
      int n;
      n = 0;
      u_analog_source.send(code);
      while (n < 8) begin
         @(posedge mclk);
         #1;
         n++;
         if (refValid === 1'b1) break;
      end
      check("latency", 16'(n + 1), 16'h0004);
      check(name, refOut, exp);
   endtask : sample

   task automatic test_defaults;
      check("kind", {15'h0, channelKindCurrent}, 16'h0000);
      check("ch2", {15'h0, channelTwoBipolar}, 16'h0001);
      rdchk("ctrl", REG_CTRL, 16'h0000);
      rdchk("vmin", REG_VMIN, VMIN_RST);
      rdchk("vmax", REG_VMAX, VMAX_RST);
      rdchk("imin", REG_IMIN, IMIN_RST);
      rdchk("imax", REG_IMAX, IMAX_RST);
      rdchk("filt", REG_FILT, FILT_RST);
      rdchk("bendx", REG_BENDX, BEND_RST);
      rdchk("bendy", REG_BENDY, BEND_RST);
      rdchk("none", REG_ASSIGN, ASSIGN_NONE);
      $display("test defaults done");
   endtask : test_defaults

   task automatic test_access;
      assignedFuncs <= 16'h0005;
      wr(REG_ASSIGN, 16'h00ff);
      rdchk("assign", REG_ASSIGN, 16'h0005);
      wr(REG_VMAX, 16'h00ff);
      rdchk("vclamp", REG_VMAX, VOLT_FULL);
      wr(REG_IMAX, 16'hffff);
      rdchk("iclamp", REG_IMAX, CURR_FULL);
      wr(REG_FILT, 16'h0fff);
      rdchk("fclamp", REG_FILT, FILT_MAX);
      wr(REG_FILT, 16'h0000);
      wr(4'hf, 16'h1234);
      rdchk("unmapped", 4'hf, 16'h0000);
      wr(REG_CH2, 16'h0000);
      check("ch2off", {15'h0, channelTwoBipolar}, 16'h0000);
      rdchk("ch2rd", REG_CH2, 16'h0000);
      wr(REG_CH2, 16'h0001);
      check("ch2on", {15'h0, channelTwoBipolar}, 16'h0001);
      $display("test access done");
   endtask : test_access

   task automatic test_voltage;
      sample("vfull", 16'hffff, PCT_FULL);
      wr(REG_VMIN, 16'h0014);
      sample("vmid", 16'h9999, 16'h1388);
      wr(REG_VMIN, 16'h0000);
      wr(REG_BENDX, 16'h1388);
      wr(REG_BENDY, 16'h07d0);
      sample("bendhi", 16'h9999, 16'h0e10);
      sample("bendlo", 16'h3333, 16'h0320);
      wr(REG_BENDX, 16'h0000);
      wr(REG_BENDY, 16'h0000);
      wr(REG_CTRL, 16'h0002);
      rdchk("vforced", REG_CTRL, 16'h0000);
      $display("test voltage done");
   endtask : test_voltage

   task automatic test_current;
      wr(REG_IMIN, 16'h0028);
      wr(REG_CTRL, 16'h0001);
      check("kindi", {15'h0, channelKindCurrent}, 16'h0001);
      sample("iuni", 16'hcccc, 16'h1d4c);
      wr(REG_CTRL, 16'h0003);
      rdchk("bidir", REG_CTRL, 16'h0003);
      sample("ibi", 16'hcccc, 16'h1388);
      wr(REG_IMIN, IMIN_BIDIR - 16'h0001);
      rdchk("iforced", REG_CTRL, 16'h0001);
      wr(REG_IMIN, 16'h0000);
      wr(REG_CTRL, 16'h0000);
      $display("test current done");
   endtask : test_current

   task automatic test_filter;
      wr(REG_FILT, 16'h0001);
      // First result after a cutoff is set still shows the last settled value
      sample("fhold", 16'h0000, 16'h1d4c);
      repeat (3000) @(posedge mclk);
      sample("fzero2", 16'h0000, 16'h0000);
      u_analog_source.send(16'hffff);
      repeat (4) @(posedge mclk);
      #1;
      check("fstep", {15'h0, refOut < PCT_FULL}, 16'h0001);
      repeat (3000) @(posedge mclk);
      u_analog_source.send(16'hffff);
      repeat (4) @(posedge mclk);
      #1;
      check("fsettle", {15'h0, refOut >= 16'h26ac}, 16'h0001);
      wr(REG_FILT, 16'h0000);
      sample("fpass", 16'hffff, PCT_FULL);
      rdchk("result", REG_RESULT, PCT_FULL);
      $display("test filter done");
   endtask : test_filter

   task automatic conclude;
      $display("checks %0d mismatches %0d", numChecks, failCount);
      if (failCount == 0 && numChecks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : conclude

   initial begin
      repeat (16) @(posedge mclk);
      resetn <= 1'b1;
      @(posedge mclk);
      test_defaults();
      test_access();
      test_voltage();
      test_current();
      test_filter();
      conclude();
   end

   // The tests need under 10000 cycles; allow four times that
   initial begin
      #320000;
      failCount++;
      conclude();
   end
endmodule : analog_input_conditioning_tb_top
